// ==== hdl/dptl_regs.vh ====
`ifndef DPTL_REGS_VH
`define DPTL_REGS_VH

// Timebase.
`define DPTL_CLK_HZ          40000000
`define DPTL_TICK_MS         100
`define DPTL_TICK_CYC        ((`DPTL_CLK_HZ / 1000) * `DPTL_TICK_MS)

// Register byte offsets.
`define DPTL_OFS_CTRL        6'h00
`define DPTL_OFS_UV_DELAY    6'h04
`define DPTL_OFS_OUT_SEL     6'h08
`define DPTL_OFS_TERM_SEL    6'h0c
`define DPTL_OFS_STATUS      6'h10
`define DPTL_OFS_IRQ_STAT    6'h14
`define DPTL_OFS_IRQ_MASK    6'h18
`define DPTL_OFS_HOLD_FREQ   6'h1c
`define DPTL_OFS_HOLD_CURR   6'h20

// Control register bits.
`define DPTL_CTRL_FAN_WARN   0
`define DPTL_CTRL_RUN        1
`define DPTL_CTRL_STOP       2

// Undervoltage delay in 0.1 s steps.
`define DPTL_UV_DELAY_MAX    10'd600
`define DPTL_UV_DELAY_RST    10'd0

// Function select codes.
`define DPTL_SEL_W           6
`define DPTL_TERM_SEL_MAX    6'd54
`define DPTL_FN_RESET        6'd3
`define DPTL_FN_INHIBIT      6'd5
`define DPTL_FN_FAN_WARN     6'd8
`define DPTL_FN_UV_WARN      6'd11

// Status register bits.
`define DPTL_ST_RUN          0
`define DPTL_ST_PWR_EN       1
`define DPTL_ST_TRIP         2
`define DPTL_ST_INHIBIT      3
`define DPTL_ST_UV_BLOCK     4
`define DPTL_ST_FAN_WARN     5

// Interrupt bits.
`define DPTL_IRQ_W           6
`define DPTL_IRQ_FAN_TRIP    0
`define DPTL_IRQ_UV_TRIP     1
`define DPTL_IRQ_OH_TRIP     2
`define DPTL_IRQ_INHIBIT     3
`define DPTL_IRQ_FAN_WARN    4
`define DPTL_IRQ_UV_WARN     5

// Display state codes.
`define DPTL_DISP_IDLE       3'd0
`define DPTL_DISP_RUN        3'd1
`define DPTL_DISP_INHIBIT    3'd2
`define DPTL_DISP_FAN_TRIP   3'd3
`define DPTL_DISP_UV_TRIP    3'd4
`define DPTL_DISP_OH_TRIP    3'd5
`define DPTL_DISP_UV_BLOCK   3'd6

`endif

// ==== hdl/dptl_sync.v ====
`timescale 1ns/1ps
module dptl_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk_in,
    input  wire             rst_in,
    // Asynchronous levels in, synchronised levels out
    input  wire [WIDTH-1:0] d_in,
    output reg  [WIDTH-1:0] q_out
);
    reg [WIDTH-1:0] meta_q;

    always @(posedge clk_in) begin
        if (rst_in) begin
            meta_q <= {WIDTH{1'b0}};
            q_out  <= {WIDTH{1'b0}};
        end else begin
            meta_q <= d_in;
            q_out  <= meta_q;
        end
    end
endmodule // dptl_sync

// ==== hdl/dptl_timer.v ====
`timescale 1ns/1ps
module dptl_timer #(
    parameter TICK_CYCLES = 4000000
) (
    // Clock and reset
    input  wire       clk_in,
    input  wire       rst_in,
    // Condition present and delay in 0.1 s steps
    input  wire       active_in,
    input  wire [9:0] delay_in,
    // High while the condition has lasted the whole delay
    output reg        expired_out
);
    reg [31:0] div_q;
    reg [9:0]  step_q;
    wire       tick;

    assign tick = (div_q == TICK_CYCLES - 1);

    // The divider restarts with the condition so every step is a full 0.1 s.
    always @(posedge clk_in) begin
        if (rst_in || !active_in) begin
            div_q       <= 32'h0000_0000;
            step_q      <= 10'h000;
            expired_out <= 1'b0;
        end else begin
            div_q <= tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
            if (tick && step_q != 10'h3ff) begin
                step_q <= step_q + 10'h001;
            end
            expired_out <= (step_q >= delay_in);
        end
    end
endmodule // dptl_timer

// ==== hdl/dptl_top.v ====
`timescale 1ns/1ps
`include "dptl_regs.vh"
module dptl_top #(
    parameter TICK_CYCLES = `DPTL_TICK_CYC
) (
    // Clock and reset
    input  wire        clk_in,
    input  wire        rst_in,
    // Avalon-MM slave
    input  wire [5:0]  avs_address_in,
    input  wire        avs_read_in,
    input  wire        avs_write_in,
    input  wire [31:0] avs_writedata_in,
    input  wire [3:0]  avs_byteenable_in,
    output reg  [31:0] avs_readdata_out,
    output reg         avs_waitrequest_out,
    // Protection inputs from pins
    input  wire        fan_err_in,
    input  wire        undervoltage_in,
    input  wire        overheat_in,
    input  wire [4:0]  term_in,
    // Operating values from the drive core
    input  wire [15:0] op_freq_in,
    input  wire [15:0] op_curr_in,
    // Drive outputs
    output reg         pwr_en_out,
    output reg         trip_out,
    output reg  [2:0]  disp_state_out,
    output reg         relay_out,
    output reg         dout_out,
    output reg         irq_out
);
    // Synchronised pins.
    wire [7:0] pins_s;
    wire       fan_s;
    wire       uv_s;
    wire       oh_s;
    wire [4:0] term_s;

    dptl_sync #(
        .WIDTH (8)
    ) u_sync (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .d_in   ({overheat_in, undervoltage_in, fan_err_in, term_in}),
        .q_out  (pins_s)
    );

    assign term_s = pins_s[4:0];
    assign fan_s  = pins_s[5];
    assign uv_s   = pins_s[6];
    assign oh_s   = pins_s[7];

    // Registers.
    reg                   fan_warn_mode_q;
    reg [9:0]             uv_delay_q;
    reg [`DPTL_SEL_W-1:0] relay_sel_q;
    reg [`DPTL_SEL_W-1:0] dout_sel_q;
    reg [29:0]            term_sel_q;
    reg [`DPTL_IRQ_W-1:0] irq_stat_q;
    reg [`DPTL_IRQ_W-1:0] irq_mask_q;
    reg [15:0]            hold_freq_q;
    reg [15:0]            hold_curr_q;

    // Drive state.
    reg        run_q;
    reg        inhibit_q;
    reg        trip_fan_q;
    reg        trip_uv_q;
    reg        trip_oh_q;
    reg        rst_term_q;
    reg        fan_warn_q;
    reg        uv_warn_q;

    // Bus decode.
    wire       wr_go;
    wire       rd_go;
    wire       wr_ctrl;
    reg [31:0] rd_data;

    assign wr_go   = avs_write_in && !avs_waitrequest_out;
    assign rd_go   = avs_read_in && avs_waitrequest_out;
    assign wr_ctrl = wr_go && (avs_address_in == `DPTL_OFS_CTRL) && avs_byteenable_in[0];

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  be;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (be[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    // Terminal functions.
    reg        term_inhibit;
    reg        term_reset;
    reg [29:0] term_sel_d;
    reg [31:0] term_new;
    integer    t;

    always @* begin
        term_inhibit = 1'b0;
        term_reset   = 1'b0;
        term_sel_d   = term_sel_q;
        term_new     = merge({2'b00, term_sel_q}, avs_writedata_in, avs_byteenable_in);
        for (t = 0; t < 5; t = t + 1) begin
            if (term_s[t] && term_sel_q[t*6 +: 6] == `DPTL_FN_INHIBIT) begin
                term_inhibit = 1'b1;
            end
            if (term_s[t] && term_sel_q[t*6 +: 6] == `DPTL_FN_RESET) begin
                term_reset = 1'b1;
            end
            // Out of range codes leave that terminal's field unchanged.
            if (term_new[t*6 +: 6] <= `DPTL_TERM_SEL_MAX) begin
                term_sel_d[t*6 +: 6] = term_new[t*6 +: 6];
            end
        end
    end

    // Undervoltage delay timer.
    wire uv_expired;

    dptl_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_uv_timer (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .active_in   (uv_s),
        .delay_in    (uv_delay_q),
        .expired_out (uv_expired)
    );

    wire trip_any;
    wire fan_trip_ev;
    wire uv_trip_ev;
    wire oh_trip_ev;
    wire inhibit_ev;
    wire resume;
    wire pwr_en_d;
    wire [`DPTL_IRQ_W-1:0] irq_ev;
    wire [31:0] uv_delay_new;

    assign trip_any    = trip_fan_q || trip_uv_q || trip_oh_q;
    assign fan_trip_ev = fan_s && !fan_warn_mode_q && !trip_fan_q;
    assign uv_trip_ev  = uv_expired && !trip_uv_q;
    assign oh_trip_ev  = oh_s && !trip_oh_q;
    assign inhibit_ev  = term_inhibit && run_q && !inhibit_q;
    assign resume      = wr_ctrl && avs_writedata_in[`DPTL_CTRL_RUN] && !term_inhibit;
    assign uv_delay_new = merge({22'h0, uv_delay_q}, avs_writedata_in, avs_byteenable_in);
    // Undervoltage blocks at once, before the trip is declared.
    assign pwr_en_d    = run_q && !trip_any && !inhibit_q && !term_inhibit
                         && !uv_s && !oh_s && !(fan_s && !fan_warn_mode_q);
    assign irq_ev      = {uv_s && !uv_warn_q,
                          fan_s && fan_warn_mode_q && !fan_warn_q,
                          inhibit_ev, oh_trip_ev, uv_trip_ev, fan_trip_ev};

    // Register writes and protection state.
    always @(posedge clk_in) begin
        if (rst_in) begin
            fan_warn_mode_q <= 1'b0;
            uv_delay_q      <= `DPTL_UV_DELAY_RST;
            relay_sel_q     <= 6'h00;
            dout_sel_q      <= 6'h00;
            term_sel_q      <= 30'h0;
            irq_mask_q      <= 6'h00;
            irq_stat_q      <= 6'h00;
            hold_freq_q     <= 16'h0000;
            hold_curr_q     <= 16'h0000;
            run_q           <= 1'b0;
            inhibit_q       <= 1'b0;
            trip_fan_q      <= 1'b0;
            trip_uv_q       <= 1'b0;
            trip_oh_q       <= 1'b0;
            rst_term_q      <= 1'b0;
            fan_warn_q      <= 1'b0;
            uv_warn_q       <= 1'b0;
        end else begin
            rst_term_q <= term_reset;
            fan_warn_q <= fan_s && fan_warn_mode_q;
            uv_warn_q  <= uv_s;
            if (wr_go) begin
                if (avs_address_in == `DPTL_OFS_CTRL && avs_byteenable_in[0]) begin
                    fan_warn_mode_q <= avs_writedata_in[`DPTL_CTRL_FAN_WARN];
                end else if (avs_address_in == `DPTL_OFS_UV_DELAY) begin
                    // Settings beyond 60 s saturate at the maximum.
                    if (uv_delay_new > {22'h0, `DPTL_UV_DELAY_MAX}) begin
                        uv_delay_q <= `DPTL_UV_DELAY_MAX;
                    end else begin
                        uv_delay_q <= uv_delay_new[9:0];
                    end
                end else if (avs_address_in == `DPTL_OFS_OUT_SEL) begin
                    if (avs_byteenable_in[0]) begin
                        relay_sel_q <= avs_writedata_in[5:0];
                    end
                    if (avs_byteenable_in[1]) begin
                        dout_sel_q <= avs_writedata_in[13:8];
                    end
                end else if (avs_address_in == `DPTL_OFS_TERM_SEL) begin
                    term_sel_q <= term_sel_d;
                end else if (avs_address_in == `DPTL_OFS_IRQ_MASK && avs_byteenable_in[0]) begin
                    irq_mask_q <= avs_writedata_in[`DPTL_IRQ_W-1:0];
                end
            end
            // A new event wins over a write-one clear in the same cycle.
            if (wr_go && avs_address_in == `DPTL_OFS_IRQ_STAT && avs_byteenable_in[0]) begin
                irq_stat_q <= (irq_stat_q & ~avs_writedata_in[`DPTL_IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end

            // Trip latches; reset terminal edge clears them unless the cause persists.
            if (term_reset && !rst_term_q) begin
                trip_fan_q <= fan_s && !fan_warn_mode_q;
                trip_uv_q  <= uv_expired;
                trip_oh_q  <= oh_s;
            end else begin
                trip_fan_q <= trip_fan_q || fan_trip_ev;
                trip_uv_q  <= trip_uv_q || uv_trip_ev;
                trip_oh_q  <= trip_oh_q || oh_trip_ev;
            end

            if (inhibit_ev) begin
                inhibit_q   <= 1'b1;
                hold_freq_q <= op_freq_in;
                hold_curr_q <= op_curr_in;
            end else if (resume) begin
                inhibit_q <= 1'b0;
            end

            // Run needs a fresh command after any trip or inhibit.
            if (trip_any || fan_trip_ev || uv_trip_ev || oh_trip_ev || inhibit_ev) begin
                run_q <= 1'b0;
            end else if (wr_ctrl && avs_writedata_in[`DPTL_CTRL_STOP]) begin
                run_q <= 1'b0;
            end else if (resume) begin
                run_q <= 1'b1;
            end
        end
    end

    // Read mux.
    always @* begin
        rd_data = 32'h0000_0000;
        if (avs_address_in == `DPTL_OFS_CTRL) begin
            rd_data[`DPTL_CTRL_FAN_WARN] = fan_warn_mode_q;
        end else if (avs_address_in == `DPTL_OFS_UV_DELAY) begin
            rd_data[9:0] = uv_delay_q;
        end else if (avs_address_in == `DPTL_OFS_OUT_SEL) begin
            rd_data[5:0]  = relay_sel_q;
            rd_data[13:8] = dout_sel_q;
        end else if (avs_address_in == `DPTL_OFS_TERM_SEL) begin
            rd_data[29:0] = term_sel_q;
        end else if (avs_address_in == `DPTL_OFS_STATUS) begin
            rd_data[`DPTL_ST_RUN]      = run_q;
            rd_data[`DPTL_ST_PWR_EN]   = pwr_en_out;
            rd_data[`DPTL_ST_TRIP]     = trip_any;
            rd_data[`DPTL_ST_INHIBIT]  = inhibit_q;
            rd_data[`DPTL_ST_UV_BLOCK] = uv_s;
            rd_data[`DPTL_ST_FAN_WARN] = fan_warn_q;
        end else if (avs_address_in == `DPTL_OFS_IRQ_STAT) begin
            rd_data[`DPTL_IRQ_W-1:0] = irq_stat_q;
        end else if (avs_address_in == `DPTL_OFS_IRQ_MASK) begin
            rd_data[`DPTL_IRQ_W-1:0] = irq_mask_q;
        end else if (avs_address_in == `DPTL_OFS_HOLD_FREQ) begin
            rd_data[15:0] = hold_freq_q;
        end else if (avs_address_in == `DPTL_OFS_HOLD_CURR) begin
            rd_data[15:0] = hold_curr_q;
        end
    end

    // Every access waits exactly one cycle so read data can be registered.
    always @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
            if (rd_go) begin
                avs_readdata_out <= rd_data;
            end
        end
    end

    // Output stage.
    always @(posedge clk_in) begin
        if (rst_in) begin
            pwr_en_out     <= 1'b0;
            trip_out       <= 1'b0;
            disp_state_out <= `DPTL_DISP_IDLE;
            relay_out      <= 1'b0;
            dout_out       <= 1'b0;
            irq_out        <= 1'b0;
        end else begin
            pwr_en_out <= pwr_en_d;
            trip_out   <= trip_any;
            relay_out  <= (relay_sel_q == `DPTL_FN_FAN_WARN && fan_s && fan_warn_mode_q)
                       || (relay_sel_q == `DPTL_FN_UV_WARN && uv_s);
            dout_out   <= (dout_sel_q == `DPTL_FN_FAN_WARN && fan_s && fan_warn_mode_q)
                       || (dout_sel_q == `DPTL_FN_UV_WARN && uv_s);
            irq_out    <= |(irq_stat_q & irq_mask_q);
            if (trip_oh_q) begin
                disp_state_out <= `DPTL_DISP_OH_TRIP;
            end else if (trip_fan_q) begin
                disp_state_out <= `DPTL_DISP_FAN_TRIP;
            end else if (trip_uv_q) begin
                disp_state_out <= `DPTL_DISP_UV_TRIP;
            end else if (uv_s) begin
                disp_state_out <= `DPTL_DISP_UV_BLOCK;
            end else if (inhibit_q) begin
                disp_state_out <= `DPTL_DISP_INHIBIT;
            end else if (run_q) begin
                disp_state_out <= `DPTL_DISP_RUN;
            end else begin
                disp_state_out <= `DPTL_DISP_IDLE;
            end
        end
    end
endmodule // dptl_top

// ==== verification/dptl_asserts.sv ====
`timescale 1ns/1ps
module dptl_asserts (
    // Clock and reset
    input wire       clk_in,
    input wire       rst_in,
    // Bus and pins
    input wire [5:0] avs_address_in,
    input wire       avs_read_in,
    input wire       avs_write_in,
    input wire       avs_waitrequest_out,
    input wire       undervoltage_in,
    input wire       overheat_in,
    input wire [4:0] term_in,
    // Drive outputs
    input wire       pwr_en_out,
    input wire       trip_out,
    input wire [2:0] disp_state_out
);
    // Cycles since the last accepted control write; saturates so it never wraps.
    reg [3:0] since_run_q;
    always @(posedge clk_in) begin
        if (rst_in)
            since_run_q <= 4'hf;
        else if (avs_write_in && !avs_waitrequest_out && avs_address_in == 6'h00)
            since_run_q <= 4'h0;
        else if (since_run_q != 4'hf)
            since_run_q <= since_run_q + 4'h1;
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    a_bus_answers:
        assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
            |=> !avs_waitrequest_out) else $error("bus answer late");
    a_wait_single:
        assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
            else $error("waitrequest low too long");
    a_oh_blocks:
        assert property ($rose(overheat_in) ##1 overheat_in [*4] |-> !pwr_en_out)
            else $error("overheat left power on");
    a_uv_blocks:
        assert property ($rose(undervoltage_in) ##1 undervoltage_in [*4] |-> !pwr_en_out)
            else $error("undervoltage left power on");
    a_trip_blocks:
        assert property (trip_out [*2] |-> !pwr_en_out) else $error("power on during trip");
    a_trip_shown:
        assert property (trip_out [*2] |-> disp_state_out inside {3'h3, 3'h4, 3'h5})
            else $error("trip not displayed");
    a_inhibit_blocks:
        assert property ((disp_state_out == 3'h2) [*2] |-> !pwr_en_out)
            else $error("power on during inhibit");
    a_trip_latched:
        assert property ((trip_out && term_in == 5'h00) [*6] |=> trip_out)
            else $error("trip cleared without terminal");
    a_run_needs_cmd:
        assert property ($rose(pwr_en_out) && $past(disp_state_out) != 3'h6 |-> since_run_q < 4'h5)
            else $error("power on without run command");
endmodule // dptl_asserts

bind dptl_top dptl_asserts u_asserts (.clk_in, .rst_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_waitrequest_out, .undervoltage_in, .overheat_in, .term_in,
    .pwr_en_out, .trip_out, .disp_state_out);

// ==== verification/dptl_plant.sv ====
`timescale 1ns/1ps
// Sensors, terminals and power stage around the block. The stage keeps its
// readings for two cycles after losing enable, then reads zero, as a real stage would.
module dptl_plant (
    // Clock
    input  wire        clk_in,
    // Levels asked for by the bench: fan, undervoltage, overheat
    input  wire [2:0]  fault_set_in,
    input  wire [4:0]  term_set_in,
    input  wire [15:0] freq_set_in,
    input  wire [15:0] curr_set_in,
    // Power stage enable
    input  wire        pwr_en_in,
    // Pins of the block
    output reg  [2:0]  fault_out,
    output reg  [4:0]  term_out,
    output reg  [15:0] op_freq_out,
    output reg  [15:0] op_curr_out
);
    reg [1:0] en_q;
    initial begin
        fault_out = 3'h0;
        term_out = 5'h00;
        op_freq_out = 16'h0;
        op_curr_out = 16'h0;
        en_q = 2'h0;
    end
    always @(posedge clk_in) begin
        fault_out <= fault_set_in;
        term_out <= term_set_in;
        en_q <= {en_q[0], pwr_en_in};
        op_freq_out <= (pwr_en_in || en_q != 2'h0) ? freq_set_in : 16'h0;
        op_curr_out <= (pwr_en_in || en_q != 2'h0) ? curr_set_in : 16'h0;
    end
endmodule // dptl_plant

// ==== verification/dptl_tb_top.sv ====
`timescale 1ns/1ps
module dptl_tb_top;
    reg         clk_in = 1'h0;
    reg         rst_in = 1'h1;
    reg  [5:0]  adr = 6'h00;
    reg         rd = 1'h0;
    reg         wr = 1'h0;
    reg  [31:0] wdat = 32'h0;
    reg         fan = 1'h0;
    reg         uv = 1'h0;
    reg         oh = 1'h0;
    reg  [4:0]  term = 5'h00;
    reg  [15:0] freq = 16'h0;
    reg  [15:0] curr = 16'h0;
    reg  [31:0] rdat;
    integer     miscompares = 0;
    integer     checked = 0;
    wire [31:0] rdata;
    wire        wreq, pwr_en, trip, relay, dout, irq;
    wire [2:0]  disp, pins;
    wire [4:0]  term_pin;
    wire [15:0] freq_pin, curr_pin;

    dptl_plant plant (.clk_in(clk_in), .fault_set_in({fan, uv, oh}), .term_set_in(term),
        .freq_set_in(freq), .curr_set_in(curr), .pwr_en_in(pwr_en), .fault_out(pins),
        .term_out(term_pin), .op_freq_out(freq_pin), .op_curr_out(curr_pin));

    // A short tick keeps the undervoltage delay to tens of cycles.
    dptl_top #(.TICK_CYCLES(10)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_byteenable_in(4'hf), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .fan_err_in(pins[2]), .undervoltage_in(pins[1]),
        .overheat_in(pins[0]), .term_in(term_pin), .op_freq_in(freq_pin),
        .op_curr_in(curr_pin), .pwr_en_out(pwr_en), .trip_out(trip),
        .disp_state_out(disp), .relay_out(relay), .dout_out(dout), .irq_out(irq));

    initial forever #12.5 clk_in = ~clk_in;

    task end_sim;
        begin
            if (miscompares == 0 && checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task cyc(input integer n);
        repeat (n) @(posedge clk_in);
    endtask

    // One bus access; an edge passes after release so requests never merge.
    task bus(input w, input [5:0] a, input [31:0] d);
        integer n;
        begin
            adr <= a;
            wdat <= d;
            wr <= w;
            rd <= !w;
            n = 0;
            @(posedge clk_in);
            while (wreq !== 1'h0 && n < 20) begin
                n = n + 1;
                @(posedge clk_in);
            end
            rdat = rdata;
            wr <= 1'h0;
            rd <= 1'h0;
            if (wreq !== 1'h0) begin
                chk(32'h0, 32'h1);
                end_sim;
            end
            @(posedge clk_in);
        end
    endtask

    task rchk(input [5:0] a, input [31:0] e);
        begin
            bus(1'h0, a, 32'h0);
            chk(rdat, e);
        end
    endtask

    // Clears a latched trip through the reset terminal on P2.
    task clear_trip;
        begin
            term <= 5'h02;
            cyc(6);
            term <= 5'h00;
            cyc(2);
        end
    endtask

    initial begin
        cyc(10);
        rst_in <= 1'h0;
        cyc(2);
        rchk(6'h00, 32'h0);
        rchk(6'h04, 32'h0);
        rchk(6'h24, 32'h0);
        bus(1'h1, 6'h04, 32'h3ff);
        rchk(6'h04, 32'h258);
        bus(1'h1, 6'h0c, 32'h36db6db6);
        rchk(6'h0c, 32'h36db6db6);
        bus(1'h1, 6'h0c, 32'hf7);
        rchk(6'h0c, 32'hf6);
        bus(1'h1, 6'h0c, 32'hc5);
        bus(1'h1, 6'h18, 32'h3f);
        rchk(6'h18, 32'h3f);
        freq <= 16'h1234;
        curr <= 16'h0567;
        bus(1'h1, 6'h00, 32'h2);
        cyc(4);
        chk(pwr_en, 1'h1);
        chk(disp, 3'h1);
        rchk(6'h10, 32'h3);
        term <= 5'h01;
        cyc(6);
        chk(pwr_en, 1'h0);
        chk(disp, 3'h2);
        freq <= 16'hbeef;
        rchk(6'h1c, 32'h1234);
        rchk(6'h20, 32'h0567);
        chk(irq, 1'h1);
        bus(1'h1, 6'h00, 32'h2);
        cyc(4);
        chk(pwr_en, 1'h0);
        term <= 5'h00;
        cyc(6);
        chk(pwr_en, 1'h0);
        bus(1'h1, 6'h18, 32'h0);
        cyc(3);
        chk(irq, 1'h0);
        bus(1'h1, 6'h14, 32'h3f);
        bus(1'h1, 6'h18, 32'h3f);
        rchk(6'h14, 32'h0);
        bus(1'h1, 6'h00, 32'h2);
        cyc(4);
        chk(pwr_en, 1'h1);
        fan <= 1'h1;
        cyc(6);
        chk(pwr_en, 1'h0);
        chk(trip, 1'h1);
        chk(disp, 3'h3);
        clear_trip;
        chk(trip, 1'h1);
        fan <= 1'h0;
        cyc(4);
        clear_trip;
        chk(trip, 1'h0);
        bus(1'h1, 6'h08, 32'h0808);
        bus(1'h1, 6'h00, 32'h3);
        cyc(4);
        fan <= 1'h1;
        cyc(6);
        chk({relay, dout, pwr_en, trip}, 4'he);
        oh <= 1'h1;
        cyc(6);
        chk(pwr_en, 1'h0);
        chk(disp, 3'h5);
        fan <= 1'h0;
        oh <= 1'h0;
        cyc(4);
        clear_trip;
        chk({relay, trip}, 2'h0);
        bus(1'h1, 6'h08, 32'h000b);
        bus(1'h1, 6'h04, 32'h2);
        bus(1'h1, 6'h00, 32'h2);
        cyc(4);
        chk(pwr_en, 1'h1);
        uv <= 1'h1;
        cyc(5);
        chk({pwr_en, relay, dout, trip}, 4'h4);
        chk(disp, 3'h6);
        cyc(7);
        uv <= 1'h0;
        cyc(4);
        uv <= 1'h1;
        cyc(16);
        chk(trip, 1'h0);
        cyc(12);
        chk(trip, 1'h1);
        chk(disp, 3'h4);
        chk(irq, 1'h1);
        uv <= 1'h0;
        cyc(4);
        clear_trip;
        bus(1'h1, 6'h00, 32'h2);
        cyc(4);
        chk(pwr_en, 1'h1);
        bus(1'h1, 6'h00, 32'h4);
        cyc(4);
        chk({pwr_en, disp}, 4'h0);
        bus(1'h1, 6'h14, 32'h3f);
        cyc(3);
        chk(irq, 1'h0);
        end_sim;
    end
endmodule // dptl_tb_top
